// *** shared/pwmsl_pkg.sv ***
// constants, field layout and types of the pwm slice
package pwmsl_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned IDX_W  = 14;
  localparam int unsigned VAL_W  = 16;

  // register indices; byte address is four times the index
  localparam logic [13:0] IDX_ERS  = 14'h048C;
  localparam logic [13:0] IDX_CLK  = 14'h048D;
  localparam logic [13:0] IDX_LDS  = 14'h048E;
  localparam logic [13:0] IDX_PR   = 14'h048F;
  localparam logic [13:0] IDX_CLOCK_PRESCALE_VALUE = 14'h0491;
  localparam logic [13:0] IDX_PIPO = 14'h0492;
  localparam logic [13:0] IDX_GIR  = 14'h0493;
  localparam logic [13:0] IDX_GIE  = 14'h0494;
  localparam logic [13:0] IDX_CON  = 14'h0495;
  localparam logic [13:0] IDX_CFG  = 14'h0496;
  localparam logic [13:0] IDX_P1   = 14'h0497;
  localparam logic [13:0] IDX_P2   = 14'h0499;
  localparam logic [13:0] IDX_MLD  = 14'h049E;
  localparam logic [13:0] IDX_MEN  = 14'h049F;

  // field positions
  localparam int unsigned CON_EN   = 7;
  localparam int unsigned CON_LD   = 2;
  localparam int unsigned CON_POL  = 1;
  localparam int unsigned CON_NOW  = 0;
  localparam int unsigned CFG_OUT_TWO_POLARITY = 7;
  localparam int unsigned CFG_OUT_ONE_POLARITY = 6;
  localparam int unsigned CFG_PUSH_PULL_ENABLE = 3;
  localparam int unsigned FLG_TWO  = 1;
  localparam int unsigned FLG_ONE  = 0;

  // select codes with no source behind them
  localparam logic [3:0] ERS_OFF     = 4'h0;
  localparam logic [3:0] ERS_RSV_LO  = 4'hE;
  localparam logic [3:0] CLK_RSV     = 4'hF;
  localparam logic [2:0] LDS_OFF     = 3'h0;
  localparam logic [2:0] LDS_RSV     = 3'h7;

  // reset values
  localparam logic [7:0]  RST8  = 8'h00;
  localparam logic [15:0] RST16 = 16'h0000;

  typedef enum logic [2:0] {
    MODE_LEFT   = 3'h0,
    MODE_RIGHT  = 3'h1,
    MODE_CENTER = 3'h2,
    MODE_VAR    = 3'h3,
    MODE_CSET   = 3'h4,
    MODE_CTOG   = 3'h5,
    MODE_RSV6   = 3'h6,
    MODE_RSV7   = 3'h7
  } pwmsl_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_UP   = 2'b01,
    ST_DOWN = 2'b11,
    ST_HOLD = 2'b10
  } pwmsl_state_t;

  typedef struct packed {
    logic slice_out_two;
    logic slice_out_one;
  } pwmsl_out_t;

  typedef struct packed {
    logic [15:0] clk_src;
    logic [15:0] ers_src;
    logic [7:0]  ld_src;
  } pwmsl_src_t;
endpackage

// *** design/pwmsl_prescale.sv ***
// divides the selected pwm clock edges by the prescale value plus one
`timescale 1ns/1ps
module pwmsl_prescale
  import pwmsl_pkg::*;
#(
  parameter int unsigned DIV_W = 8
)
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             pclk_en,
  input  wire logic             run,
  input  wire logic             tick_in,
  input  wire logic [DIV_W-1:0] div,
  output logic                  tick_out
);
  logic [DIV_W-1:0] cnt_q;

  // a fresh enable always starts a full division
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_q <= '0;
    else if (pclk_en)
    begin
      if (!run)
        cnt_q <= '0;
      else if (tick_in)
        cnt_q <= (cnt_q == div) ? '0 : cnt_q + 1'b1;
    end
  end

  assign tick_out = run & tick_in & (cnt_q == div);
endmodule

// *** design/pwmsl_top.sv ***
// sixteen bit pwm instance with one slice, apb register slave
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
module pwmsl_top
  import pwmsl_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        pclk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire pwmsl_src_t  src_in,
  input  wire logic [2:0]  peer_reload_done,
  output pwmsl_out_t       slice_out,
  output logic             instance_irq_flag,
  output logic      [2:0]  peer_reload,
  output logic      [2:0]  peer_enable
);
  // byte merges for one and two byte registers
  function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] wd, input logic [3:0] st);
    merge8 = st[0] ? wd[7:0] : old;
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] st);
    merge16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
  endfunction

  function automatic logic mapped(input logic [13:0] idx);
    case (idx)
      IDX_ERS, IDX_CLK, IDX_LDS, IDX_PR, IDX_CLOCK_PRESCALE_VALUE, IDX_PIPO, IDX_GIR,
      IDX_GIE, IDX_CON, IDX_CFG, IDX_P1, IDX_P2, IDX_MLD, IDX_MEN: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  // p clocks at the tail of a period: timer + p exceeds period
  function automatic logic in_tail(input logic [15:0] t, input logic [15:0] pr, input logic [15:0] p);
    in_tail = ({1'b0, t} + {1'b0, p}) > {1'b0, pr};
  endfunction

  logic [3:0]   ers_q;
  logic [3:0]   clk_q;
  logic [2:0]   lds_q;
  logic [15:0]  pr_q;
  logic [7:0]   clock_prescale_value_q;
  logic [7:0]   pipos_q;
  logic [1:0]   gir_q;
  logic [1:0]   gie_q;
  logic         en_q;
  logic         ld_q;
  logic         epol_q;
  logic         enow_q;
  logic [7:0]   cfg_q;
  logic [15:0]  p1_q;
  logic [15:0]  p2_q;
  logic [2:0]   peer_ld_q;
  logic [2:0]   peer_en_q;
  logic [15:0]  pr_b_q;
  logic [15:0]  p1_b_q;
  logic [15:0]  p2_b_q;
  logic [15:0]  tmr_q;
  pwmsl_state_t st_q;
  logic         raw1_q;
  logic         raw2_q;
  logic         phase_q;
  pwmsl_out_t   out_q;
  logic [31:0]  prdata_q;
  pwmsl_src_t   sync1_q;
  pwmsl_src_t   sync2_q;
  logic         clk_lvl_q;
  logic         ldt_lvl_q;

  logic [13:0]  idx;
  logic         wr;
  logic [31:0]  rd_data;
  logic         clk_lvl;
  logic         ldt_lvl;
  logic         ers_active;
  logic         ld_ext;
  logic         tick;
  logic         running;
  logic         per_evt;
  logic         reload_pt;
  logic         raw1_d;
  logic         raw2_d;
  logic [1:0]   evt;
  logic         m1;
  logic         m2;
  logic         gate1;
  logic         gate2;
  pwmsl_mode_t  mode;

  assign idx  = paddr[15:2];
  assign wr   = psel & penable & pwrite & pclk_en;
  assign mode = pwmsl_mode_t'(cfg_q[2:0]);

  // pins and other domains pass two flops before anything reads them
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else if (pclk_en)
    begin
      sync1_q <= src_in;
      sync2_q <= sync1_q;
    end
  end

  assign clk_lvl    = (clk_q != CLK_RSV) & sync2_q.clk_src[clk_q];
  assign ldt_lvl    = (lds_q != LDS_OFF) & (lds_q != LDS_RSV) & sync2_q.ld_src[lds_q];
  assign ers_active = (ers_q != ERS_OFF) & (ers_q < ERS_RSV_LO)
                      & (sync2_q.ers_src[ers_q] ^ epol_q);
  assign ld_ext     = en_q & ldt_lvl & ~ldt_lvl_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clk_lvl_q <= 1'b0;
      ldt_lvl_q <= 1'b0;
    end
    else if (pclk_en)
    begin
      clk_lvl_q <= clk_lvl;
      ldt_lvl_q <= ldt_lvl;
    end
  end

  pwmsl_prescale #(
    .DIV_W (8)
  ) i_pwmsl_prescale (
    .pclk     (pclk),
    .presetn  (presetn),
    .pclk_en  (pclk_en),
    .run      (en_q),
    .tick_in  (clk_lvl & ~clk_lvl_q),
    .div      (clock_prescale_value_q),
    .tick_out (tick)
  );

  // plain configuration registers; narrow fields drop reserved bits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ers_q   <= RST8[3:0];
      clk_q   <= RST8[3:0];
      lds_q   <= RST8[2:0];
      pr_q    <= RST16;
      clock_prescale_value_q  <= RST8;
      pipos_q <= RST8;
      gie_q   <= RST8[1:0];
      cfg_q   <= RST8;
      p1_q    <= RST16;
      p2_q    <= RST16;
      epol_q  <= 1'b0;
      enow_q  <= 1'b0;
    end
    else if (wr)
    begin
      case (idx)
        IDX_ERS:  if (pstrb[0]) ers_q <= pwdata[3:0];
        IDX_CLK:  if (pstrb[0]) clk_q <= pwdata[3:0];
        IDX_LDS:  if (pstrb[0]) lds_q <= pwdata[2:0];
        IDX_PR:   pr_q    <= merge16(pr_q, pwdata, pstrb);
        IDX_CLOCK_PRESCALE_VALUE: clock_prescale_value_q  <= merge8(clock_prescale_value_q, pwdata, pstrb);
        IDX_PIPO: pipos_q <= merge8(pipos_q, pwdata, pstrb);
        IDX_GIE:  if (pstrb[0]) gie_q <= pwdata[1:0];
        IDX_CFG:  cfg_q   <= merge8(cfg_q, pwdata, pstrb) & 8'hCF;
        IDX_P1:   p1_q    <= merge16(p1_q, pwdata, pstrb);
        IDX_P2:   p2_q    <= merge16(p2_q, pwdata, pstrb);
        IDX_CON:
        begin
          if (pstrb[0])
          begin
            epol_q <= pwdata[CON_POL];
            enow_q <= pwdata[CON_NOW];
          end
        end
        default: ;
      endcase
    end
  end

  // enable bit, reachable from its own register and from the shared mirror
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en_q      <= 1'b0;
      peer_en_q <= 3'h0;
    end
    else if (wr && pstrb[0])
    begin
      if (idx == IDX_CON)
        en_q <= pwdata[CON_EN];
      if (idx == IDX_MEN)
      begin
        en_q      <= pwdata[0];
        peer_en_q <= pwdata[3:1];
      end
    end
  end

  // reload request: hardware clears it at the reload point, a new set wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ld_q      <= 1'b0;
      peer_ld_q <= 3'h0;
    end
    else if (pclk_en)
    begin
      if (reload_pt)
        ld_q <= 1'b0;
      peer_ld_q <= peer_ld_q & ~peer_reload_done;
      if (wr && pstrb[0] && idx == IDX_CON)
        ld_q <= pwdata[CON_LD];
      if (wr && pstrb[0] && idx == IDX_MLD)
      begin
        ld_q      <= pwdata[0];
        peer_ld_q <= pwdata[3:1];
      end
      if (ld_ext)
        ld_q <= 1'b1;
    end
  end

  // working copies follow the registers while disabled; while enabled they take them only at a reload point
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pr_b_q <= RST16;
      p1_b_q <= RST16;
      p2_b_q <= RST16;
    end
    else if (pclk_en && (!en_q || reload_pt))
    begin
      pr_b_q <= pr_q;
      p1_b_q <= p1_q;
      p2_b_q <= p2_q;
    end
  end

  assign running = (st_q == ST_UP) || (st_q == ST_DOWN);
  assign per_evt = tick && (((st_q == ST_UP) && (tmr_q == pr_b_q))
                   || ((st_q == ST_DOWN) && (tmr_q == 16'h0000)));
  // center aligned spans two period events, so it reloads only at the bottom
  assign reload_pt = per_evt & ld_q & ((mode != MODE_CENTER) | (st_q == ST_DOWN));

  // timer: up from zero to period, down again in center aligned mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q  <= ST_IDLE;
      tmr_q <= RST16;
    end
    else if (pclk_en)
    begin
      if (!en_q)
      begin
        st_q  <= ST_IDLE;
        tmr_q <= RST16;
      end
      else if (tick)
      begin
        case (st_q)
          ST_IDLE:
            st_q <= ST_UP;
          ST_UP, ST_DOWN:
          begin
            if (ers_active && (enow_q || per_evt))
            begin
              st_q  <= ST_HOLD;
              tmr_q <= RST16;
            end
            else if (st_q == ST_UP)
            begin
              if (tmr_q != pr_b_q)
                tmr_q <= tmr_q + 16'h0001;
              else if (mode == MODE_CENTER)
                st_q <= ST_DOWN;
              else
                tmr_q <= RST16;
            end
            else if (tmr_q == 16'h0000)
              st_q <= ST_UP;
            else
              tmr_q <= tmr_q - 16'h0001;
          end
          ST_HOLD:
          begin
            tmr_q <= RST16;
            if (!ers_active)
              st_q <= ST_UP;
          end
          default:
            st_q <= ST_IDLE;
        endcase
      end
    end
  end

  assign m1 = running && (tmr_q == p1_b_q);
  assign m2 = running && (tmr_q == p2_b_q);

  // next level of each slice output, before polarity
  always_comb
  begin
    raw1_d = 1'b0;
    raw2_d = 1'b0;
    case (mode)
      MODE_LEFT:
      begin
        raw1_d = tmr_q < p1_b_q;
        raw2_d = tmr_q < p2_b_q;
      end
      MODE_RIGHT, MODE_CENTER:
      begin
        raw1_d = in_tail(tmr_q, pr_b_q, p1_b_q);
        raw2_d = in_tail(tmr_q, pr_b_q, p2_b_q);
      end
      MODE_VAR:
      begin
        raw1_d = m2 ? 1'b0 : (m1 ? 1'b1 : raw1_q);
        raw2_d = raw1_d;
      end
      MODE_CSET:
      begin
        raw1_d = raw1_q | m1;
        raw2_d = raw2_q | m2;
      end
      MODE_CTOG:
      begin
        raw1_d = raw1_q ^ m1;
        raw2_d = raw2_q ^ m2;
      end
      default: ;
    endcase
    if (!running)
    begin
      raw1_d = 1'b0;
      raw2_d = 1'b0;
    end
  end

  // flag events for each mode, sampled on the pwm tick only
  always_comb
  begin
    evt = 2'b00;
    case (mode)
      MODE_VAR, MODE_CSET, MODE_CTOG:
        evt = {m2, m1};
      MODE_CENTER:
        evt = {raw2_d ^ raw2_q, raw1_d ^ raw1_q};
      MODE_RIGHT:
        evt = {raw2_d & ~raw2_q, raw1_d & ~raw1_q};
      MODE_LEFT:
        evt = {~raw2_d & raw2_q, ~raw1_d & raw1_q};
      default: ;
    endcase
    if (!(tick && en_q))
      evt = 2'b00;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      raw1_q  <= 1'b0;
      raw2_q  <= 1'b0;
      phase_q <= 1'b0;
    end
    else if (pclk_en)
    begin
      if (!en_q)
      begin
        raw1_q  <= 1'b0;
        raw2_q  <= 1'b0;
        phase_q <= 1'b0;
      end
      else if (tick)
      begin
        raw1_q <= raw1_d;
        raw2_q <= raw2_d;
        if (per_evt)
          phase_q <= ~phase_q;
      end
    end
  end

  // flags: a software write stores, a hardware event in the same cycle wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      gir_q <= RST8[1:0];
    else if (pclk_en)
    begin
      if (wr && idx == IDX_GIR && pstrb[0])
        gir_q <= pwdata[1:0] | evt;
      else
        gir_q <= gir_q | evt;
    end
  end

  // push-pull only shapes left and right aligned modes
  assign gate1 = !(cfg_q[CFG_PUSH_PULL_ENABLE] && (mode == MODE_LEFT || mode == MODE_RIGHT)) || !phase_q;
  assign gate2 = !(cfg_q[CFG_PUSH_PULL_ENABLE] && (mode == MODE_LEFT || mode == MODE_RIGHT)) || phase_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      out_q <= '0;
    else if (pclk_en)
    begin
      out_q.slice_out_one <= (en_q & raw1_q & gate1) ^ cfg_q[CFG_OUT_ONE_POLARITY];
      out_q.slice_out_two <= (en_q & raw2_q & gate2) ^ cfg_q[CFG_OUT_TWO_POLARITY];
    end
  end

  always_comb
  begin
    rd_data = 32'h0000_0000;
    case (idx)
      IDX_ERS:  rd_data = {28'h0, ers_q};
      IDX_CLK:  rd_data = {28'h0, clk_q};
      IDX_LDS:  rd_data = {29'h0, lds_q};
      IDX_PR:   rd_data = {16'h0, pr_q};
      IDX_CLOCK_PRESCALE_VALUE: rd_data = {24'h0, clock_prescale_value_q};
      IDX_PIPO: rd_data = {24'h0, pipos_q};
      IDX_GIR:  rd_data = {30'h0, gir_q};
      IDX_GIE:  rd_data = {30'h0, gie_q};
      IDX_CON:  rd_data = {24'h0, en_q, 4'h0, ld_q, epol_q, enow_q};
      IDX_CFG:  rd_data = {24'h0, cfg_q};
      IDX_P1:   rd_data = {16'h0, p1_q};
      IDX_P2:   rd_data = {16'h0, p2_q};
      IDX_MLD:  rd_data = {28'h0, peer_ld_q, ld_q};
      IDX_MEN:  rd_data = {28'h0, peer_en_q, en_q};
      default:  rd_data = 32'h0000_0000;
    endcase
  end

  // read data is caught in the setup cycle so it leaves a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= 32'h0000_0000;
    else if (pclk_en && psel && !penable)
      prdata_q <= rd_data;
  end

  assign prdata            = prdata_q;
  assign pready            = pclk_en;
  assign pslverr           = psel & penable & ~mapped(idx);
  assign slice_out         = out_q;
  assign instance_irq_flag = |(gir_q & gie_q);
  assign peer_reload       = peer_ld_q;
  assign peer_enable       = peer_en_q;
endmodule

// *** bench/pwmsl_monitor.sv ***
// concurrent checks on the pwm slice top ports
`timescale 1ns/1ps
module pwmsl_monitor
  import pwmsl_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        pclk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire pwmsl_out_t  slice_out,
  input wire logic        instance_irq_flag,
  input wire logic [2:0]  peer_reload,
  input wire logic [2:0]  peer_enable
);
  wire acc    = psel && penable && pwrite && pready && pstrb[0];
  wire men_wr = acc && paddr[15:2] == IDX_MEN;
  wire mld_wr = acc && paddr[15:2] == IDX_MLD;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_pready_enable: assert property (pready == pclk_en) else $error("pready not equal to clock enable");
  a_unmapped_error: assert property (psel && penable && paddr[15:2] == 14'h0490 |-> pslverr)
    else $error("no error on unmapped access");
  a_mapped_clean: assert property (psel && penable && paddr[15:2] == IDX_CON |-> !pslverr)
    else $error("error on mapped access");
  // reset is checked while it is active, so no disable here
  a_reset_quiet: assert property (disable iff (1'b0) !presetn |-> slice_out == 2'b00 && !instance_irq_flag)
    else $error("outputs active during reset");
  a_frozen_hold: assert property (!pclk_en |=> $stable(slice_out) && $stable(peer_enable))
    else $error("outputs moved while clock enable low");
  a_enable_mirror: assert property (men_wr |=> peer_enable == $past(pwdata[3:1]))
    else $error("enable mirror not written");
  a_enable_hold: assert property (!men_wr |=> $stable(peer_enable))
    else $error("enable mirror changed without write");
  a_reload_mirror: assert property (mld_wr |=> peer_reload == $past(pwdata[3:1]))
    else $error("reload mirror not written");
  a_reload_norise: assert property (!mld_wr |=> (peer_reload & ~$past(peer_reload)) == 3'h0)
    else $error("reload mirror set without write");
endmodule

bind pwmsl_top pwmsl_monitor i_mon (.pclk, .presetn, .pclk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pstrb, .pready, .pslverr, .slice_out, .instance_irq_flag, .peer_reload, .peer_enable);

// *** bench/tb.sv ***
// register and waveform tests of the pwm slice
`timescale 1ns/1ps
module tb;
  import pwmsl_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b1;
  logic        ers_pin = 1'b0;
  logic        pclk_en = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0]  pstrb = 4'hF;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  pwmsl_src_t  src = '0;
  logic [2:0]  peer_reload_done = 3'h0;
  pwmsl_out_t  slice_out;
  logic        instance_irq_flag;
  logic [2:0]  peer_reload;
  logic [2:0]  peer_enable;
  logic [31:0] rdata;
  logic        rerr;
  logic [1:0]  cdiv = 2'h0;
  int          err_count = 0;
  int          total_checks = 0;
  int          cyc = 0;
  logic [13:0] ridx [6] = '{IDX_CON, IDX_CFG, IDX_P1, IDX_P2, IDX_MLD, IDX_MEN};

  pwmsl_top i_pwmsl_top (.pclk(pclk), .presetn(presetn), .pclk_en(pclk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .src_in(src), .peer_reload_done(peer_reload_done), .slice_out(slice_out),
    .instance_irq_flag(instance_irq_flag), .peer_reload(peer_reload), .peer_enable(peer_enable));

  always #10 pclk = ~pclk;
  // pwm source clock: one rising edge every four pclk cycles
  always @(posedge pclk)
  begin
    cdiv <= cdiv + 2'h1;
    src.clk_src[0] <= cdiv[1];
    src.ers_src[1] <= ers_pin;
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      err_count++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      $display("BAD %s expected %h seen %h", n, e, s);
      err_count++;
    end
  endtask

  task automatic xfer(input logic w, input logic [13:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [13:0] idx, input logic [31:0] d);
    xfer(1'b1, idx, d);
  endtask

  task automatic rd(input string n, input logic [13:0] idx, input logic [31:0] e);
    xfer(1'b0, idx, 32'h0);
    chk(n, rdata, e);
  endtask

  // window of 128 pclk spans whole periods in every mode used here
  task automatic meas(input int e1, input int e2);
    int h1;
    int h2;
    h1 = 0;
    h2 = 0;
    repeat (128)
    begin
      @(posedge pclk);
      h1 += int'(slice_out.slice_out_one === 1'b1);
      h2 += int'(slice_out.slice_out_two === 1'b1);
    end
    chk("high_one", h1, e1);
    chk("high_two", h2, e2);
  endtask

  task automatic edges(input int e);
    int n;
    logic p;
    n = 0;
    p = slice_out.slice_out_one;
    repeat (128)
    begin
      @(posedge pclk);
      n += int'(slice_out.slice_out_one === 1'b1 && p === 1'b0);
      p = slice_out.slice_out_one;
    end
    chk("rises_one", n, e);
  endtask

  task automatic run(input logic [7:0] cfg, input logic [15:0] p1, input logic [15:0] p2, input logic [7:0] con,
                     input int e1, input int e2);
    wr(IDX_CON, 32'h0);
    wr(IDX_CFG, {24'h0, cfg});
    wr(IDX_P1, {16'h0, p1});
    wr(IDX_P2, {16'h0, p2});
    wr(IDX_GIR, 32'h0);
    wr(IDX_CON, {24'h0, con});
    repeat (64) @(posedge pclk);
    meas(e1, e2);
    $display("run cfg %h con %h done", cfg, con);
  endtask

  task automatic irq_is(input logic e);
    @(negedge pclk);
    chk("irq", instance_irq_flag, {31'h0, e});
  endtask

  initial
  begin
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ridx[i])
      rd("reset_val", ridx[i], 32'h0);
    wr(IDX_P2, 32'hABCD);
    pstrb <= 4'h2;
    wr(IDX_P2, 32'h1234);
    pstrb <= 4'hF;
    rd("p2_bytes", IDX_P2, 32'h12CD);
    wr(IDX_GIE, 32'hFFFF_FFFF);
    rd("gie_rsv", IDX_GIE, 32'h3);
    wr(IDX_GIE, 32'h0);
    wr(IDX_CON, 32'h43);
    rd("con_rsv", IDX_CON, 32'h3);
    xfer(1'b0, 14'h0490, 32'h0);
    chk("unmapped_err", rerr, 32'h1);
    chk("unmapped_data", rdata, 32'h0);
    wr(IDX_PR, 32'h3);
    $display("register test done");
    run(8'h00, 16'h1, 16'h2, 8'h80, 32, 64);
    wr(IDX_P1, 32'h3);
    meas(32, 64);
    wr(IDX_CON, 32'h84);
    repeat (64) @(posedge pclk);
    rd("ld_clear", IDX_CON, 32'h80);
    meas(96, 64);
    wr(IDX_CON, 32'h0);
    rd("flags_left", IDX_GIR, 32'h3);
    irq_is(1'b0);
    wr(IDX_GIE, 32'h2);
    irq_is(1'b1);
    wr(IDX_GIR, 32'h1);
    irq_is(1'b0);
    $display("flag test done");
    wr(IDX_CLOCK_PRESCALE_VALUE, 32'h1);
    run(8'h00, 16'h1, 16'h2, 8'h80, 32, 64);
    edges(4);
    wr(IDX_CLOCK_PRESCALE_VALUE, 32'h0);
    run(8'h01, 16'h1, 16'h2, 8'h80, 32, 64);
    run(8'h02, 16'h1, 16'h2, 8'h80, 32, 64);
    rd("flags_center", IDX_GIR, 32'h3);
    run(8'h03, 16'h1, 16'h3, 8'h80, 64, 64);
    run(8'h04, 16'h1, 16'h2, 8'h80, 128, 128);
    run(8'h05, 16'h1, 16'h2, 8'h80, 64, 64);
    rd("flags_cmp", IDX_GIR, 32'h3);
    run(8'h06, 16'h1, 16'h2, 8'h80, 0, 0);
    run(8'h07, 16'h1, 16'h2, 8'h80, 0, 0);
    run(8'h08, 16'h1, 16'h2, 8'h80, 16, 32);
    run(8'hC0, 16'h1, 16'h2, 8'h80, 96, 64);
    pclk_en <= 1'b0;
    repeat (6) @(posedge pclk);
    pclk_en <= 1'b1;
    wr(IDX_CON, 32'h0);
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk("out_default", slice_out, 32'h3);
    rd("cfg_kept", IDX_CFG, 32'hC0);
    wr(IDX_ERS, 32'h1);
    ers_pin <= 1'b1;
    run(8'h00, 16'h1, 16'h2, 8'h81, 0, 0);
    run(8'h00, 16'h1, 16'h2, 8'h80, 0, 0);
    run(8'h00, 16'h1, 16'h2, 8'h83, 32, 64);
    wr(IDX_ERS, 32'h0);
    wr(IDX_MEN, 32'hF);
    rd("men_con", IDX_CON, 32'h83);
    chk("peer_en", peer_enable, 32'h7);
    wr(IDX_MLD, 32'hE);
    @(negedge pclk);
    chk("peer_ld", peer_reload, 32'h7);
    @(posedge pclk);
    peer_reload_done <= 3'h7;
    @(posedge pclk);
    peer_reload_done <= 3'h0;
    @(negedge pclk);
    chk("peer_ld_done", peer_reload, 32'h0);
    $display("mirror test done");
    tally_and_finish();
  end
endmodule
